// File: inc/arf_pkg.sv
package arf_pkg;
  // -------------------------------------------------------------------
  // register map
  // -------------------------------------------------------------------
  localparam logic [7:0] INPUT_SELECT_ADDR = 8'h7c;
  localparam logic [7:0] RESULT_LOW_ADDR   = 8'h78;
  localparam logic [7:0] RESULT_HIGH_ADDR  = 8'h79;
  localparam logic [7:0] STATUS_ADDR       = 8'h7a;
  localparam logic [7:0] INPUT_SELECT_RST  = 8'h00;
  localparam logic [9:0] RESULT_RST        = 10'h000;
  // -------------------------------------------------------------------
  // field positions
  // -------------------------------------------------------------------
  localparam int REF_HI      = 7;
  localparam int REF_LO      = 6;
  localparam int LEFT_ADJ    = 5;
  localparam int CHAN_HI     = 4;
  localparam int DONE_BIT    = 4;
  localparam int BUSY_BIT    = 6;
  // -------------------------------------------------------------------
  // codes
  // -------------------------------------------------------------------
  localparam logic [9:0] SE_MAX      = 10'h3ff;
  localparam logic [9:0] DIFF_POSMAX = 10'h1ff;
  localparam logic [9:0] DIFF_NEGMAX = 10'h200;
  localparam logic [4:0] CHAN_SE_LAST   = 5'h07;
  localparam logic [4:0] CHAN_DIFF_FIRST = 5'h10;
  localparam logic [4:0] CHAN_DIFF_LAST  = 5'h1d;
  localparam logic [4:0] CHAN_BANDGAP   = 5'h1e;
  localparam logic [4:0] CHAN_GROUND    = 5'h1f;
  typedef enum logic [1:0] {
    REF_EXTERNAL = 2'h0,
    REF_SUPPLY   = 2'h1,
    REF_RESERVED = 2'h2,
    REF_INTERNAL = 2'h3
  } arf_ref_e;
  typedef enum logic [1:0] {
    SRC_SINGLE, SRC_DIFF, SRC_BANDGAP, SRC_GROUND
  } arf_src_e;
endpackage

// File: hw/arf_result_format.sv
`timescale 1ns/1ps
module arf_result_format (
  input  wire logic       leftAdjust,
  input  wire logic [9:0] resultCode,
  output logic      [7:0] resultLow,
  output logic      [7:0] resultHigh
);
  // -------------------------------------------------------------------
  // alignment of the stored result
  // -------------------------------------------------------------------
  always_comb begin
    if (leftAdjust) begin
      resultHigh = resultCode[9:2];
      resultLow  = {resultCode[1:0], 6'h00};
    end else begin
      resultHigh = {6'h00, resultCode[9:8]};
      resultLow  = resultCode[7:0];
    end
  end
endmodule

// File: hw/arf_adc_control.sv
// Contract
// - after the done flag sets, the finished result is readable in the pair
// - single-ended results are unsigned 10-bit codes, 0x000 to 0x3FF
// - differential results are signed, saturating at 0x1FF and 0x200
// - select register: reference 7:6, left adjust 5, channel 4:0, reset 0
// - reference written mid-conversion takes effect only after it completes
// - reference 00 external pin, 01 supply, 10 reserved, 11 internal 1.1V
// - left adjust one aligns the result left, zero aligns it right
// - left adjust change reformats the visible result at once
// - left: bits 9:2 high, 1:0 at low 7:6; right: low holds 7:0
// - channels 0-7 single, 16-29 differential, 30 bandgap, 31 ground
// - done flag sets when a conversion finishes and the result is updated
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
module arf_adc_control (
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic [7:0]  regAddr,
  input  wire logic [7:0]  regWdata,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [7:0]  regRdata,
  input  wire logic        convStart,
  input  wire logic        convEnd,
  input  wire logic [10:0] coreCode,
  output logic      [1:0]  referenceSelect,
  output logic      [4:0]  channelSelect,
  output logic      [1:0]  sourceKind,
  output logic             conversionDoneFlag,
  output logic             convBusy
);
  // -------------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------------
  function automatic logic [1:0] chanKind(input logic [4:0] ch);
    if (ch <= arf_pkg::CHAN_SE_LAST)
      chanKind = 2'(arf_pkg::SRC_SINGLE);
    else if (ch == arf_pkg::CHAN_BANDGAP)
      chanKind = 2'(arf_pkg::SRC_BANDGAP);
    else if (ch == arf_pkg::CHAN_GROUND)
      chanKind = 2'(arf_pkg::SRC_GROUND);
    else
      chanKind = 2'(arf_pkg::SRC_DIFF);
  endfunction

  // coreCode is a signed 11-bit raw value from the core; clamp per mode
  function automatic logic [9:0] shapeCode(input logic [1:0]  kind,
                                           input logic [10:0] raw);
    logic signed [10:0] s;
    s = raw;
    if (kind == 2'(arf_pkg::SRC_DIFF)) begin
      if (s > $signed({1'b0, arf_pkg::DIFF_POSMAX}))
        shapeCode = arf_pkg::DIFF_POSMAX;
      else if (s < -11'sd512)
        shapeCode = arf_pkg::DIFF_NEGMAX;
      else
        shapeCode = raw[9:0];
    end else begin
      if (s < 11'sd0)
        shapeCode = 10'h000;
      else if (s > $signed({1'b0, arf_pkg::SE_MAX}))
        shapeCode = arf_pkg::SE_MAX;
      else
        shapeCode = raw[9:0];
    end
  endfunction

  // -------------------------------------------------------------------
  // registers
  // -------------------------------------------------------------------
  logic [7:0] inputSelect;
  logic [9:0] resultCode;
  logic [7:0] resultLow;
  logic [7:0] resultHigh;
  logic       leftAdjust;
  logic       clearDone;

  assign leftAdjust = inputSelect[arf_pkg::LEFT_ADJ];
  assign clearDone  = regWrite && (regAddr == arf_pkg::STATUS_ADDR)
                      && regWdata[arf_pkg::DONE_BIT];

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      inputSelect <= arf_pkg::INPUT_SELECT_RST;
    end else if (regWrite && regAddr == arf_pkg::INPUT_SELECT_ADDR) begin
      inputSelect <= regWdata;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      convBusy <= 1'b0;
    end else if (convEnd) begin
      convBusy <= 1'b0;
    end else if (convStart) begin
      convBusy <= 1'b1;
    end
  end

  // selection tracks the register until a conversion runs, then is held
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      referenceSelect <= 2'h0;
      channelSelect   <= 5'h00;
    end else if (!convBusy || convEnd) begin
      referenceSelect <= inputSelect[arf_pkg::REF_HI:arf_pkg::REF_LO];
      channelSelect   <= inputSelect[arf_pkg::CHAN_HI:0];
    end
  end

  assign sourceKind = chanKind(channelSelect);

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      resultCode <= arf_pkg::RESULT_RST;
    end else if (convEnd && convBusy) begin
      resultCode <= shapeCode(sourceKind, coreCode);
    end
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      conversionDoneFlag <= 1'b0;
    end else if (convEnd && convBusy) begin
      conversionDoneFlag <= 1'b1;
    end else if (clearDone) begin
      conversionDoneFlag <= 1'b0;
    end
  end

  // -------------------------------------------------------------------
  // result alignment, follows leftAdjust combinationally
  // -------------------------------------------------------------------
  arf_result_format uFormat (
    .leftAdjust (leftAdjust),
    .resultCode (resultCode),
    .resultLow  (resultLow),
    .resultHigh (resultHigh)
  );

  // -------------------------------------------------------------------
  // read port
  // -------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      regRdata <= 8'h00;
    end else if (regRead) begin
      unique case (regAddr)
        arf_pkg::INPUT_SELECT_ADDR: regRdata <= inputSelect;
        arf_pkg::RESULT_LOW_ADDR:   regRdata <= resultLow;
        arf_pkg::RESULT_HIGH_ADDR:  regRdata <= resultHigh;
        arf_pkg::STATUS_ADDR:
          regRdata <= {1'b0, convBusy, 1'b0, conversionDoneFlag, 4'h0};
        default:                    regRdata <= 8'h00;
      endcase
    end else begin
      regRdata <= 8'h00;
    end
  end
endmodule

// File: test/arf_checker.sv
`timescale 1ns/1ps
module arf_checker (
  input wire logic       clk_sys,
  input wire logic       rst_b,
  input wire logic       regRead,
  input wire logic [7:0] regRdata,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic       regWrite,
  input wire logic       convStart,
  input wire logic       convEnd,
  input wire logic       convBusy,
  input wire logic       conversionDoneFlag,
  input wire logic [1:0] referenceSelect,
  input wire logic [4:0] channelSelect,
  input wire logic [1:0] sourceKind
);
  wire clr = regWrite && regAddr == 8'h7a && regWdata[4];
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  property p_rd_idle; !$past(regRead) |-> regRdata == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("stray data");
  property p_busy_set; convStart |=> convBusy; endproperty
  a_busy_set: assert property (p_busy_set) else $error("no busy");
  property p_idle; !convBusy && !convStart |=> !convBusy; endproperty
  a_idle: assert property (p_idle) else $error("busy unasked");
  property p_frozen;
    convBusy && !convEnd |=> $stable({referenceSelect, channelSelect});
  endproperty
  a_frozen: assert property (p_frozen) else $error("select moved");
  property p_done; convBusy && convEnd |=> conversionDoneFlag && !convBusy;
  endproperty
  a_done: assert property (p_done) else $error("no done");
  property p_src; $rose(conversionDoneFlag) |-> $past(convEnd) && $past(convBusy);
  endproperty
  a_src: assert property (p_src) else $error("flag unasked");
  property p_hold; conversionDoneFlag && !clr |=> conversionDoneFlag;
  endproperty
  a_hold: assert property (p_hold) else $error("flag lost");
  property p_kind; channelSelect[4:3] != 2'b01 |-> sourceKind ==
    (!channelSelect[4] ? 2'h0 : channelSelect == 5'h1e ? 2'h2 :
     channelSelect == 5'h1f ? 2'h3 : 2'h1); endproperty
  a_kind: assert property (p_kind) else $error("bad kind");
endmodule
bind arf_adc_control arf_checker arf_checker_inst (.*);

// File: test/arf_core_model.sv
`timescale 1ns/1ps
module arf_core_model (
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic        convStart,
  input  wire logic [3:0]  waitCycles,
  input  wire logic [10:0] nextCode,
  output logic             convEnd,
  output logic      [10:0] coreCode
);
  logic [4:0] count;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      count <= 5'h00;
      convEnd <= 1'b0;
      coreCode <= 11'h000;
    end else begin
      convEnd <= count == 5'h01;
      coreCode <= (count == 5'h01) ? nextCode : ~coreCode;
      if (convStart) begin
        count <= {1'b0, waitCycles} + 5'h01;
      end else if (count != 5'h00) begin
        count <= count - 5'h01;
      end
    end
  end
endmodule

// File: test/tb_adc_result_format_and_ref_select.sv
`timescale 1ns/1ps
module tb_adc_result_format_and_ref_select;
  logic        clk_sys, rst_b, regWrite, regRead, convStart, convEnd;
  logic        conversionDoneFlag, convBusy;
  logic [7:0]  regAddr, regWdata, regRdata, sel, sel2;
  logic [10:0] coreCode, nextCode;
  logic [1:0]  referenceSelect, sourceKind;
  logic [4:0]  channelSelect;
  logic [3:0]  waitCycles;
  logic [15:0] rnd, p;
  int          bad_count, n_checks;
  logic [4:0]  chans [4] = '{5'h00, 5'h07, 5'h10, 5'h1d};
  logic [10:0] edges [8] = '{11'h000, 11'h3ff, 11'h400, 11'h7ff,
                             11'h1ff, 11'h200, 11'h600, 11'h5ff};
  arf_adc_control arf_adc_control_inst (.*);
  arf_core_model arf_core_model_inst (.*);
  function automatic logic [15:0] pair(input logic [10:0] r, input logic d,
                                       input logic l);
    logic [9:0] c;
    if (d) c = r[10] ? (r < 11'h600 ? 10'h200 : r[9:0])
                     : (r > 11'h1ff ? 10'h1ff : r[9:0]);
    else c = r[10] ? 10'h000 : r[9:0];
    return l ? {c, 6'h00} : {6'h00, c};
  endfunction
  task automatic chk(input logic [7:0] e, input logic [7:0] g,
                     input string nm = "regRdata");
    n_checks++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      bad_count++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk_sys);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk_sys);
    regRead <= 1'b0;
    #1;
    chk(e, regRdata);
  endtask
  task automatic report_and_stop;
    if (bad_count == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    report_and_stop();
  end
  initial begin
    {rst_b, regWrite, regRead, convStart, regAddr, regWdata} = '0;
    {nextCode, waitCycles} = '0;
    rnd = 16'hfc5c;
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'b1;
    rd(8'h7c, 8'h00);
    rd(8'h55, 8'h00);
    wr(8'h79, 8'hff);
    rd(8'h79, 8'h00);
    wr(8'h7c, 8'h9e);
    rd(8'h7c, 8'h9e);
    wr(8'h7c, 8'h1f);
    for (int i = 0; i < 64; i++) begin
      rnd = {rnd[14:0], rnd[15] ^ rnd[13] ^ rnd[12] ^ rnd[10]};
      sel = {rnd[7:5], chans[i[5:4]]};
      sel2 = {rnd[10:8], chans[i[5:4]]};
      wr(8'h7c, sel);
      rd(8'h7c, sel);
      @(posedge clk_sys);
      convStart <= 1'b1;
      nextCode <= i[3] ? rnd[14:4] : edges[i[2:0]];
      waitCycles <= rnd[3:0] | 4'h2;
      @(posedge clk_sys);
      convStart <= 1'b0;
      wr(8'h7c, sel2);
      #1;
      chk({6'h00, sel[7:6]}, {6'h00, referenceSelect}, "referenceSelect");
      chk({3'h0, sel[4:0]}, {3'h0, channelSelect}, "channelSelect");
      for (int k = 0; k < 40 && conversionDoneFlag !== 1'b1; k++) begin
        @(posedge clk_sys);
        #1;
      end
      chk(8'h01, {7'h00, conversionDoneFlag}, "conversionDoneFlag");
      chk({6'h00, sel2[7:6]}, {6'h00, referenceSelect}, "referenceSelect");
      chk({3'h0, sel2[4:0]}, {3'h0, channelSelect}, "channelSelect");
      chk({7'h00, sel2[4]}, {6'h00, sourceKind}, "sourceKind");
      chk(8'h00, {7'h00, convBusy}, "convBusy");
      for (int j = 0; j < 2; j++) begin
        p = pair(nextCode, sel2[4], sel2[5] ^ j[0]);
        rd(8'h78, p[7:0]);
        rd(8'h79, p[15:8]);
        wr(8'h7c, sel2 ^ {2'h0, ~j[0], 5'h00});
      end
      rd(8'h7a, 8'h10);
      wr(8'h7a, 8'h10);
      rd(8'h7a, 8'h00);
    end
    report_and_stop();
  end
endmodule
